// ---- hw/gpio_function_select_mux.sv ----
// five-pin function multiplexer with apb register file and pin-change interrupt
`timescale 1ns/1ps

module gpio_function_select_mux #(
   parameter int DIV_W = 8
) (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic [gpio_mux_pkg::APB_AW-1:0] paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic                               irq,
   input  wire logic [gpio_mux_pkg::NUM_PINS-1:0] pinIn,
   output logic      [gpio_mux_pkg::NUM_PINS-1:0] pinOut,
   output logic      [gpio_mux_pkg::NUM_PINS-1:0] pinOeN,
   input  wire logic [gpio_mux_pkg::NUM_FRAME-1:0] audioPortTxFrameClock,
   input  wire logic                          interruptRequestOne,
   input  wire logic                          interruptRequestTwo,
   input  wire logic                          firstLoopClock,
   input  wire logic                          secondLoopClock,
   input  wire logic                          pwmChannelOne,
   input  wire logic                          pwmChannelTwo,
   input  wire logic                          systemClockUnderclock,
   input  wire logic                          asyncClockUnderclock,
   input  wire logic                          firstLoopLock,
   input  wire logic                          secondLoopLock,
   input  wire logic                          firstLoopClockOk,
   input  wire logic                          secondLoopClockOk
);
   import gpio_mux_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [FN_W-1:0]     pinFunctionSelect_r [NUM_PINS];
   logic [FN_W-1:0]     pinFunctionSelect_nxt [NUM_PINS];
   logic [NUM_PINS-1:0] pinDirection_r;
   logic [NUM_PINS-1:0] pinDirection_nxt;
   logic [NUM_PINS-1:0] pinLevel_r;
   logic [NUM_PINS-1:0] pinLevel_nxt;
   logic [NUM_PINS-1:0] pinOutputInvert_r;
   logic [NUM_PINS-1:0] pinOutputInvert_nxt;
   logic [NUM_PINS-1:0] status_r;
   logic [NUM_PINS-1:0] status_nxt;
   logic [NUM_PINS-1:0] mask_r;
   logic [NUM_PINS-1:0] mask_nxt;
   logic [DIV_W-1:0]    clkDiv_r;
   logic [DIV_W-1:0]    clkDiv_nxt;
   logic [31:0]         prdata_r;
   logic [31:0]         prdata_nxt;
   logic                pslverr_r;
   logic                pslverr_nxt;

   logic [NUM_PINS-1:0] pinMeta_r;
   logic [NUM_PINS-1:0] pinSync_r;
   logic [NUM_PINS-1:0] pinPrev_r;

   logic [DIV_W-1:0]    divCnt_r;
   logic [DIV_W-1:0]    divCnt_nxt;
   logic                derivedClockOut_r;
   logic                derivedClockOut_nxt;

   logic                setupPhase;
   logic                writeTake;
   logic [2:0]          ctrlIdx;
   logic                ctrlHit;
   logic [NUM_PINS-1:0] pinEvent;
   logic [NUM_PINS-1:0] frameClk;

   assign setupPhase = psel && !penable;
   assign writeTake  = psel && penable && pwrite;
   assign ctrlIdx    = paddr[4:2];
   assign ctrlHit    = (paddr[1:0] == 2'b00) && (paddr < OFS_STATUS);
   // only the first pins own a frame clock; the upper slots are tied low so that
   // the per-pin source vector never indexes past the frame clock bus
   assign frameClk   = {{(NUM_PINS-NUM_FRAME){1'b0}}, audioPortTxFrameClock};

   // ----------------------------------------------------------------
   // pad input synchroniser and change detect
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pinMeta_r <= '0;
         pinSync_r <= '0;
         pinPrev_r <= '0;
      end else begin
         pinMeta_r <= pinIn;
         pinSync_r <= pinMeta_r;
         pinPrev_r <= pinSync_r;
      end
   end

   // only pins set up as button/logic inputs raise events
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pinEvent[i] = (pinSync_r[i] ^ pinPrev_r[i]) && pinDirection_r[i]
                       && (pinFunctionSelect_r[i] == FN_LOGIC);
      end
   end

   // ----------------------------------------------------------------
   // derived clock output
   // ----------------------------------------------------------------
   // period is 2*(divider+1) system clocks; a new divider is compared against the running count at once
   always_comb begin
      if (divCnt_r >= clkDiv_r) begin
         divCnt_nxt          = '0;
         derivedClockOut_nxt = !derivedClockOut_r;
      end else begin
         divCnt_nxt          = divCnt_r + DIV_W'(1);
         derivedClockOut_nxt = derivedClockOut_r;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         divCnt_r          <= '0;
         derivedClockOut_r <= 1'b0;
      end else begin
         divCnt_r          <= divCnt_nxt;
         derivedClockOut_r <= derivedClockOut_nxt;
      end
   end

   // ----------------------------------------------------------------
   // apb register file
   // ----------------------------------------------------------------
   always_comb begin
      pinFunctionSelect_nxt = pinFunctionSelect_r;
      pinDirection_nxt      = pinDirection_r;
      pinLevel_nxt          = pinLevel_r;
      pinOutputInvert_nxt   = pinOutputInvert_r;
      mask_nxt              = mask_r;
      clkDiv_nxt            = clkDiv_r;
      prdata_nxt            = prdata_r;
      pslverr_nxt           = pslverr_r;
      status_nxt            = status_r;

      if (writeTake && ctrlHit) begin
         pinFunctionSelect_nxt[ctrlIdx] = pwdata[FN_LSB +: FN_W];
         pinDirection_nxt[ctrlIdx]      = pwdata[BIT_DIR];
         pinLevel_nxt[ctrlIdx]          = pwdata[BIT_LVL];
         pinOutputInvert_nxt[ctrlIdx]   = pwdata[BIT_INV];
      end
      if (writeTake && paddr == OFS_STATUS) begin
         status_nxt = status_r & ~pwdata[NUM_PINS-1:0];
      end
      if (writeTake && paddr == OFS_MASK) begin
         mask_nxt = pwdata[NUM_PINS-1:0];
      end
      if (writeTake && paddr == OFS_CLKDIV) begin
         clkDiv_nxt = pwdata[DIV_W-1:0];
      end
      // an event in the clearing cycle survives the clear
      status_nxt = status_nxt | pinEvent;

      // read data is captured in the setup cycle so the access cycle needs no wait
      if (setupPhase) begin
         prdata_nxt  = '0;
         pslverr_nxt = !isMapped(paddr);
         if (ctrlHit) begin
            prdata_nxt[FN_LSB +: FN_W] = pinFunctionSelect_r[ctrlIdx];
            prdata_nxt[BIT_DIR]        = pinDirection_r[ctrlIdx];
            prdata_nxt[BIT_LVL]        = pinSync_r[ctrlIdx];
            prdata_nxt[BIT_INV]        = pinOutputInvert_r[ctrlIdx];
         end else if (paddr == OFS_STATUS) begin
            prdata_nxt[NUM_PINS-1:0] = status_r;
         end else if (paddr == OFS_MASK) begin
            prdata_nxt[NUM_PINS-1:0] = mask_r;
         end else if (paddr == OFS_CLKDIV) begin
            prdata_nxt[DIV_W-1:0] = clkDiv_r;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            pinFunctionSelect_r[i] <= RST_FN;
         end
         pinDirection_r    <= {NUM_PINS{RST_DIR}};
         pinLevel_r        <= {NUM_PINS{RST_LVL}};
         pinOutputInvert_r <= {NUM_PINS{RST_INV}};
         status_r          <= '0;
         mask_r            <= '0;
         clkDiv_r          <= DIV_W'(RST_CLKDIV);
         prdata_r          <= '0;
         pslverr_r         <= 1'b0;
      end else begin
         pinFunctionSelect_r <= pinFunctionSelect_nxt;
         pinDirection_r      <= pinDirection_nxt;
         pinLevel_r          <= pinLevel_nxt;
         pinOutputInvert_r   <= pinOutputInvert_nxt;
         status_r            <= status_nxt;
         mask_r              <= mask_nxt;
         clkDiv_r            <= clkDiv_nxt;
         prdata_r            <= prdata_nxt;
         pslverr_r           <= pslverr_nxt;
      end
   end

   assign pready  = psel && penable;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r && psel && penable;
   assign irq     = |(status_r & mask_r);

   // ----------------------------------------------------------------
   // per-pin routing
   // ----------------------------------------------------------------
   pin_cfg_if cfg [NUM_PINS] ();

   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      assign cfg[g].fn     = pinFunctionSelect_r[g];
      assign cfg[g].dirIn  = pinDirection_r[g];
      assign cfg[g].level  = pinLevel_r[g];
      assign cfg[g].invert = pinOutputInvert_r[g];
      // source index equals function code; reserved slots are tied low
      assign cfg[g].src = {
         secondLoopClockOk,
         firstLoopClockOk,
         1'b0,
         secondLoopLock,
         firstLoopLock,
         asyncClockUnderclock,
         systemClockUnderclock,
         pwmChannelTwo,
         pwmChannelOne,
         1'b0,
         secondLoopClock,
         firstLoopClock,
         derivedClockOut_r,
         interruptRequestTwo,
         interruptRequestOne,
         pinLevel_r[g],
         frameClk[g]
      };
      assign pinOut[g] = cfg[g].drive;
      assign pinOeN[g] = cfg[g].oeN;

      pin_route #(
         .PIN_INDEX (g)
      ) u_route (
         .clk   (clk),
         .reset (reset),
         .p     (cfg[g])
      );
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_frame_route: assert property (@(posedge clk) disable iff (reset)
      (pinFunctionSelect_r[0] == FN_FRAME)
      |=> (pinOut[0] == ($past(audioPortTxFrameClock[0]) ^ $past(pinOutputInvert_r[0]))))
      else $error("pin one does not carry the first frame clock");

   a_irq_route: assert property (@(posedge clk) disable iff (reset)
      (pinFunctionSelect_r[1] == FN_IRQ_ONE)
      |=> (pinOut[1] == ($past(interruptRequestOne) ^ $past(pinOutputInvert_r[1]))))
      else $error("pin two does not carry the first interrupt request");

   a_level_read: assert property (@(posedge clk) disable iff (reset)
      (setupPhase && !pwrite && paddr == OFS_CTRL_BASE)
      |=> (prdata[BIT_LVL] == $past(pinSync_r[0])))
      else $error("level read does not return the sampled pin");

   a_status_sticky: assert property (@(posedge clk) disable iff (reset)
      (status_r[0] && !(writeTake && paddr == OFS_STATUS && pwdata[0])) |=> status_r[0] [*1])
      else $error("status bit lost without a clearing write");

   a_irq_level: assert property (@(posedge clk) disable iff (reset)
      ((status_r & mask_r) != '0) |-> irq ##1 (irq || (status_r & mask_r) == '0))
      else $error("interrupt output low while an unmasked bit is set");

   a_unmapped_err: assert property (@(posedge clk) disable iff (reset)
      (setupPhase && !isMapped(paddr)) ##1 (psel && penable) |-> pslverr)
      else $error("unmapped access answered without error");

endmodule : gpio_function_select_mux

// ---- hw/gpio_mux_pkg.sv ----
// constants shared by the pin function multiplexer and its per-pin router
package gpio_mux_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_PINS  = 5;
   localparam int FN_W      = 7;
   localparam int NUM_SRC   = 17;
   localparam int APB_AW    = 8;
   localparam int LAST_PIN  = 4;
   localparam int FOURTH_PIN = 3;
   localparam int NUM_FRAME = 3;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [APB_AW-1:0] OFS_CTRL_BASE = 8'h00;
   localparam logic [APB_AW-1:0] OFS_STATUS    = 8'h14;
   localparam logic [APB_AW-1:0] OFS_MASK      = 8'h18;
   localparam logic [APB_AW-1:0] OFS_CLKDIV    = 8'h1C;

   // pin control word fields
   localparam int BIT_DIR = 15;
   localparam int BIT_LVL = 11;
   localparam int BIT_INV = 10;
   localparam int FN_LSB  = 0;

   // reset values
   localparam logic            RST_DIR    = 1'b1;
   localparam logic            RST_LVL    = 1'b0;
   localparam logic            RST_INV    = 1'b0;
   localparam logic [FN_W-1:0] RST_FN     = 7'h01;
   localparam logic [7:0]      RST_CLKDIV = 8'h00;

   // ----------------------------------------------------------------
   // function codes
   // ----------------------------------------------------------------
   localparam logic [FN_W-1:0] FN_FRAME       = 7'h00;
   localparam logic [FN_W-1:0] FN_LOGIC       = 7'h01;
   localparam logic [FN_W-1:0] FN_IRQ_ONE     = 7'h02;
   localparam logic [FN_W-1:0] FN_IRQ_TWO     = 7'h03;
   localparam logic [FN_W-1:0] FN_CLKOUT      = 7'h04;
   localparam logic [FN_W-1:0] FN_LOOP1_CLK   = 7'h05;
   localparam logic [FN_W-1:0] FN_LOOP2_CLK   = 7'h06;
   localparam logic [FN_W-1:0] FN_RSVD_7      = 7'h07;
   localparam logic [FN_W-1:0] FN_PWM_ONE     = 7'h08;
   localparam logic [FN_W-1:0] FN_PWM_TWO     = 7'h09;
   localparam logic [FN_W-1:0] FN_SYS_UNDER   = 7'h0A;
   localparam logic [FN_W-1:0] FN_ASYNC_UNDER = 7'h0B;
   localparam logic [FN_W-1:0] FN_LOOP1_LOCK  = 7'h0C;
   localparam logic [FN_W-1:0] FN_LOOP2_LOCK  = 7'h0D;
   localparam logic [FN_W-1:0] FN_LOOP1_OK    = 7'h0F;
   localparam logic [FN_W-1:0] FN_LOOP2_OK    = 7'h10;
   localparam logic [FN_W-1:0] FN_LAST        = 7'h10;

   // one bit per code 00h..10h; 07h and 0Eh are reserved everywhere
   localparam logic [NUM_SRC-1:0] FN_SET_FULL   = 17'h1_BF7F;
   localparam logic [NUM_SRC-1:0] FN_SET_FOURTH = 17'h1_BF7E;
   localparam logic [NUM_SRC-1:0] FN_SET_LAST   = 17'h0_001E;

   function automatic logic fnSupported(input int pin, input logic [FN_W-1:0] fn);
      logic [NUM_SRC-1:0] set;
      set = (pin == LAST_PIN) ? FN_SET_LAST : (pin == FOURTH_PIN) ? FN_SET_FOURTH : FN_SET_FULL;
      return (fn <= FN_LAST) && set[fn[4:0]];
   endfunction : fnSupported

   function automatic logic isMapped(input logic [APB_AW-1:0] addr);
      return (addr[1:0] == 2'b00) && (addr <= OFS_CLKDIV);
   endfunction : isMapped

endpackage : gpio_mux_pkg

// ---- hw/pin_cfg_if.sv ----
// configuration, candidate sources and registered drive of one pin
`timescale 1ns/1ps
interface pin_cfg_if;
   import gpio_mux_pkg::*;
   logic [FN_W-1:0]    fn;
   logic               dirIn;
   logic               level;
   logic               invert;
   logic [NUM_SRC-1:0] src;
   logic               drive;
   logic               oeN;

   modport ctrl  (output fn, dirIn, level, invert, src, input drive, oeN);
   modport route (input fn, dirIn, level, invert, src, output drive, oeN);
endinterface : pin_cfg_if

// ---- hw/pin_route.sv ----
// per-pin function select, polarity and registered pad drive
`timescale 1ns/1ps
module pin_route #(
   parameter int PIN_INDEX = 0
) (
   input wire logic clk,
   input wire logic reset,
   pin_cfg_if.route p
);
   import gpio_mux_pkg::*;

   logic drive_r;
   logic drive_nxt;
   logic oeN_r;
   logic oeN_nxt;
   logic fnOk;

   always_comb begin
      fnOk = fnSupported(PIN_INDEX, p.fn);
      // unsupported codes never see the source vector or the invert bit
      drive_nxt = fnOk ? (p.src[p.fn[4:0]] ^ p.invert) : 1'b0;
      oeN_nxt   = p.dirIn;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         drive_r <= 1'b0;
         oeN_r   <= 1'b1;
      end else begin
         drive_r <= drive_nxt;
         oeN_r   <= oeN_nxt;
      end
   end

   assign p.drive = drive_r;
   assign p.oeN   = oeN_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_reserved_low: assert property (@(posedge clk) disable iff (reset)
      (p.fn == FN_RSVD_7 || p.fn > FN_LAST) |=> !p.drive)
      else $error("reserved code drove the pin high");

   a_logic_level: assert property (@(posedge clk) disable iff (reset)
      (p.fn == FN_LOGIC && !p.invert) |=> (p.drive == $past(p.level)))
      else $error("logic output does not follow the level bit");

   a_invert_out: assert property (@(posedge clk) disable iff (reset)
      (p.fn == FN_LOGIC && p.invert) |=> (p.drive == !$past(p.level)))
      else $error("inverted output matches the level bit");

   a_last_subset: assert property (@(posedge clk) disable iff (reset)
      (PIN_INDEX == LAST_PIN && p.fn >= FN_CLKOUT + 7'h01) |=> !p.drive)
      else $error("last pin routed a code outside its subset");

   a_dir_enable: assert property (@(posedge clk) disable iff (reset)
      $rose(p.dirIn) |=> p.oeN ##1 (p.oeN || !p.dirIn))
      else $error("pin still driven after switching to input");

endmodule : pin_route

// ---- sim/pin_partner.sv ----
// external parts on the five pins: loop-back where the block drives, button where released
`timescale 1ns/1ps
module pin_partner (
   input  wire logic [gpio_mux_pkg::NUM_PINS-1:0] pinOut,
   input  wire logic [gpio_mux_pkg::NUM_PINS-1:0] pinOeN,
   input  wire logic [gpio_mux_pkg::NUM_PINS-1:0] button,
   output logic      [gpio_mux_pkg::NUM_PINS-1:0] pinIn
);
   import gpio_mux_pkg::*;
   // a released pin shows the button, never a stale copy of the last drive
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pinIn[i] = pinOeN[i] ? button[i] : pinOut[i];
      end
   end
endmodule : pin_partner

// ---- sim/tb.sv ----
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module tb;
   import gpio_mux_pkg::*;
   logic              clk, reset, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [APB_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd, w;
   logic [4:0]        pinIn, pinOut, pinOeN, button;
   logic [14:0]       s;
   int                miscompares, comparisons, cycles, rises;
   logic              prev;

   gpio_function_select_mux #(.DIV_W(8)) uut (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
      .audioPortTxFrameClock(s[2:0]), .interruptRequestOne(s[3]), .interruptRequestTwo(s[4]),
      .firstLoopClock(s[5]), .secondLoopClock(s[6]), .pwmChannelOne(s[7]), .pwmChannelTwo(s[8]),
      .systemClockUnderclock(s[9]), .asyncClockUnderclock(s[10]), .firstLoopLock(s[11]),
      .secondLoopLock(s[12]), .firstLoopClockOk(s[13]), .secondLoopClockOk(s[14]));
   pin_partner partner (.pinOut(pinOut), .pinOeN(pinOeN), .button(button), .pinIn(pinIn));

   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic complete_run();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // apb master, entered just after a rising edge
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd  = prdata;
      err = pslverr;
      if (n >= 50) chk("pready", 32'h0000_0001, 32'h0000_0000);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic rdchk(input logic [APB_AW-1:0] a, input logic [31:0] exp, input logic bad);
      apb(1'b0, a, 32'h0000_0000);
      chk("prdata", exp, rd);
      chk("pslverr", {31'h0, bad}, {31'h0, err});
   endtask : rdchk

   // model of one pin: code set per pin and routed source
   function automatic logic expOut(input int p, input int c, input logic [31:0] cw, input logic [14:0] v);
      logic o;
      logic ok;
      ok = c <= 16 && c != 7 && c != 14 && !(p == 3 && c == 0) && !(p == 4 && (c < 1 || c > 4));
      case (c)
         0: o = v[p];
         1: o = cw[11];
         2, 3: o = v[c+1];
         5, 6: o = v[c];
         8, 9, 10, 11, 12, 13: o = v[c-1];
         15, 16: o = v[c-2];
         default: o = 1'b0;
      endcase
      return ok ? o ^ cw[10] : 1'b0;
   endfunction : expOut

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
      button = '0; s = '0; miscompares = 0; comparisons = 0; cycles = 0;
      void'($urandom(32'h7fe8d9fb));
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int p = 0; p < NUM_PINS; p++) rdchk(8'(4*p), 32'h0000_8001, 1'b0);
      chk("pinOeN", 32'h1F, {27'h0, pinOeN});
      rdchk(OFS_STATUS, 32'h0, 1'b0);
      rdchk(OFS_MASK, 32'h0, 1'b0);
      // input events on pin two: all pins are still logic inputs, only pin two's button moves
      apb(1'b1, OFS_MASK, 32'h0000_0002);
      button <= 5'b00010;
      repeat (5) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      rdchk(OFS_STATUS, 32'h2, 1'b0);
      rdchk(8'h04, 32'h0000_8801, 1'b0);
      apb(1'b1, OFS_STATUS, 32'h0000_0002);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, OFS_MASK, 32'h0000_0000);
      button <= 5'b00000;
      repeat (5) @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      rdchk(OFS_STATUS, 32'h2, 1'b0);
      apb(1'b1, OFS_STATUS, 32'h0000_001F);
      // refused accesses, then a divider write wider than its register
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      rdchk(8'h20, 32'h0, 1'b1);
      rdchk(8'h02, 32'h0, 1'b1);
      apb(1'b1, OFS_CLKDIV, 32'hFFFF_FF02);
      rdchk(OFS_CLKDIV, 32'h02, 1'b0);
      // codes 0 to 17 except 4 on every pin, random sources, invert and level, driven outputs
      for (int p = 0; p < NUM_PINS; p++) begin
         for (int c = 0; c <= 17; c++) begin
            if (c == 4) continue;
            w = {20'h0, $urandom() % 2 == 1, $urandom() % 2 == 1, 3'h0, 7'(c)};
            apb(1'b1, 8'(4*p), w);
            s <= 15'($urandom());
            repeat (3) @(posedge clk);
            chk($sformatf("pinOut%0d code %0d", p, c), {31'h0, expOut(p, c, w, s)}, {31'h0, pinOut[p]});
            chk("pinOeN", 32'h0, {31'h0, pinOeN[p]});
         end
      end
      // derived clock, divider 2: period of six cycles
      apb(1'b1, 8'h00, 32'h0000_0004);
      repeat (12) @(posedge clk);
      rises = 0;
      prev  = pinOut[0];
      repeat (24) begin
         @(posedge clk);
         if (pinOut[0] === 1'b1 && prev === 1'b0) rises++;
         prev = pinOut[0];
      end
      chk("clock rises", 32'd4, rises);
      // back to input: the pad is released one edge after the write lands
      apb(1'b1, 8'h00, 32'h0000_8001);
      @(posedge clk);
      chk("pinOeN released", 32'h1, {31'h0, pinOeN[0]});
      complete_run();
   end
endmodule : tb
